// >>> shared/fault_monitor_pkg.sv
package fault_monitor_pkg;
    localparam int          channel_count      = 16;
    localparam int          group_size         = 8;
    localparam logic [3:0]  fault_status_addr  = 4'h0;
    localparam logic [3:0]  irq_status_addr    = 4'h1;
    localparam logic [3:0]  irq_mask_addr      = 4'h2;
    localparam logic [3:0]  control_addr       = 4'h3;
    localparam int          low_group_bit      = 0;
    localparam int          high_group_bit     = 1;
    localparam int          ctl_comm_bit       = 0;
    localparam logic [15:0] irq_mask_reset     = 16'h0000;
    localparam logic [15:0] control_reset      = 16'h0000;
    localparam int          pulse_period_ns    = 10000000;
    localparam int          clk_period_ns      = 10;
    localparam int          pulse_half_cycles  = pulse_period_ns / clk_period_ns / 2;

    typedef struct packed {
        logic        run;
        logic        low_fault;
        logic        high_fault;
    } lamp_s;
endpackage

// >>> verilog/output_fault_monitor.sv
// Notes on behaviour
// - overload sense inputs are watched every clock, not only on request.
// - a failing output is toggled off and on while its fault persists.
// - fault status bit 0 flags outputs 1..8, bit 1 flags outputs 9..16.
// - the group's red diagnostic lamp turns on with its status bit.
// - low group fault lights the first diagnostic lamp, run lamp stays on.
// - high group fault lights the second diagnostic lamp, run lamp stays on.
// - no fault and communication active: run lamp on, diagnostic lamps off.
// - status bits clear by themselves once the fault disappears.
// - the diagnostic lamp goes out in the same cycle its status bit clears, unless that group's undervoltage input keeps it lit.
// - fault status is read only and after reset shows present faults.
//
// Chosen here: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module output_fault_monitor #(
    parameter int pulse_half = fault_monitor_pkg::pulse_half_cycles
) (
    input  wire logic        sys_clk_in,
    input  wire logic        rst_in,
    input  wire logic [15:0] out_cmd_in,
    input  wire logic [15:0] overload_in,
    input  wire logic        undervolt_low_in,
    input  wire logic        undervolt_high_in,
    input  wire logic [3:0]  addr_in,
    input  wire logic [15:0] wdata_in,
    input  wire logic        wr_in,
    input  wire logic        rd_in,
    output logic      [15:0] rdata_out,
    output logic      [15:0] out_drive_out,
    output logic             run_lamp_out,
    output logic             low_group_fault_lamp_out,
    output logic             high_group_fault_lamp_out,
    output logic             irq_out
);
    localparam int channels    = fault_monitor_pkg::channel_count;
    localparam int group_width = fault_monitor_pkg::group_size;
    localparam int low_bit     = fault_monitor_pkg::low_group_bit;
    localparam int high_bit    = fault_monitor_pkg::high_group_bit;
    localparam int comm_bit    = fault_monitor_pkg::ctl_comm_bit;

    // port widths fix sixteen outputs in two groups of eight
    if (channels != 16) begin : g_bad_channels
        $error("channel count must be 16");
    end
    if (group_width * 2 != channels) begin : g_bad_groups
        $error("two groups must cover all channels");
    end
    if (group_width != 8) begin : g_bad_width
        $error("group_any walks eight flags per group");
    end
    if (low_bit != 0 || high_bit != 1) begin : g_bad_bits
        $error("group bits must sit at positions 0 and 1");
    end
    if (comm_bit != 0) begin : g_bad_comm
        $error("control write mask assumes the comm bit at 0");
    end
    if (pulse_half < 1) begin : g_bad_pulse
        $error("pulse_half must be at least 1");
    end
    // a shared offset would let one strobe hit two registers
    if (fault_monitor_pkg::fault_status_addr == fault_monitor_pkg::irq_status_addr
        || fault_monitor_pkg::fault_status_addr == fault_monitor_pkg::irq_mask_addr
        || fault_monitor_pkg::fault_status_addr == fault_monitor_pkg::control_addr
        || fault_monitor_pkg::irq_status_addr == fault_monitor_pkg::irq_mask_addr
        || fault_monitor_pkg::irq_status_addr == fault_monitor_pkg::control_addr
        || fault_monitor_pkg::irq_mask_addr == fault_monitor_pkg::control_addr) begin : g_bad_map
        $error("register offsets must differ");
    end

    typedef enum logic [1:0] {
        chop_idle = 2'b00,
        chop_off  = 2'b01,
        chop_on   = 2'b10
    } chop_state_e;

    // one strobe qualified by one offset
    function automatic logic reg_hit(
        input logic       strobe,
        input logic [3:0] addr,
        input logic [3:0] target
    );
        return strobe && (addr == target);
    endfunction

    // or of one group of eight flags; group 0 covers outputs 1..8
    function automatic logic group_any(
        input logic [15:0] flags,
        input int          group_index
    );
        logic result;
        result = 1'b0;
        for (int i = 0; i < 8; i++) begin
            result = result | flags[group_index * 8 + i];
        end
        return result;
    endfunction

    // a fresh fault starts in the off half, so the driver is relieved at once
    function automatic chop_state_e next_chop(
        input chop_state_e state,
        input logic        fault,
        input logic        tick
    );
        chop_state_e result;
        result = state;
        if (!fault) begin
            result = chop_idle;
        end else begin
            unique case (state)
                chop_idle: result = chop_off;
                chop_off:  result = tick ? chop_on : chop_off;
                chop_on:   result = tick ? chop_off : chop_on;
                default:   result = chop_off;
            endcase
        end
        return result;
    endfunction

    // pin inputs, two-stage synchronisers
    logic [15:0] ovl_meta;
    logic [15:0] ovl_sync;
    logic [1:0]  uv_meta;
    logic [1:0]  uv_sync;

    always_ff @(posedge sys_clk_in) begin
        ovl_meta <= overload_in;
        uv_meta  <= {undervolt_high_in, undervolt_low_in};
    end

    always_ff @(posedge sys_clk_in) begin
        ovl_sync <= ovl_meta;
        uv_sync  <= uv_meta;
    end

    // undervoltage lights a lamp but sets no status bit
    wire logic short_low  = group_any(ovl_sync, low_bit);
    wire logic short_high = group_any(ovl_sync, high_bit);
    wire logic diag_low   = short_low | uv_sync[low_bit];
    wire logic diag_high  = short_high | uv_sync[high_bit];

    // status follows the condition directly; nothing latches a cause that is gone
    wire logic [15:0] next_fault_status = {14'h0000, short_high, short_low};
    logic [15:0] fault_status;

    // no reset on purpose: right after reset the bits show the faults present then
    always_ff @(posedge sys_clk_in) begin
        fault_status <= next_fault_status;
    end

    // one shared tick paces every chopping output, one half period apart
    logic [31:0] pulse_cnt;
    wire logic   pulse_wrap = (pulse_cnt >= 32'(pulse_half - 1));

    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            pulse_cnt <= 32'h00000000;
        end else if (pulse_wrap) begin
            pulse_cnt <= 32'h00000000;
        end else begin
            pulse_cnt <= pulse_cnt + 32'h00000001;
        end
    end

    // per-output chopper state, indexed by channel
    chop_state_e chop_state      [16];
    chop_state_e next_chop_state [16];
    logic [15:0] chop_hold;

    for (genvar i = 0; i < 16; i++) begin : g_chop
        assign next_chop_state[i] = next_chop(chop_state[i], ovl_sync[i], pulse_wrap);
        assign chop_hold[i]       = (chop_state[i] == chop_off);
    end

    always_ff @(posedge sys_clk_in) begin
        for (int i = 0; i < 16; i++) begin
            if (rst_in) begin
                chop_state[i] <= chop_idle;
            end else begin
                chop_state[i] <= next_chop_state[i];
            end
        end
    end

    // the command still wins while an output is healthy
    wire logic [15:0] next_drive = out_cmd_in & ~chop_hold;

    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            out_drive_out <= 16'h0000;
        end else begin
            out_drive_out <= next_drive;
        end
    end

    // registers
    logic [15:0] irq_status;
    logic [15:0] irq_mask;
    logic [15:0] control;

    wire logic wr_irq_status = reg_hit(wr_in, addr_in, fault_monitor_pkg::irq_status_addr);
    wire logic wr_irq_mask   = reg_hit(wr_in, addr_in, fault_monitor_pkg::irq_mask_addr);
    wire logic wr_control    = reg_hit(wr_in, addr_in, fault_monitor_pkg::control_addr);

    // rising fault edges raise sticky events; set beats write-one-to-clear
    wire logic [15:0] fault_rise      = next_fault_status & ~fault_status;
    wire logic [15:0] w1c             = wr_irq_status ? wdata_in : 16'h0000;
    wire logic [15:0] next_irq_status = (irq_status & ~w1c) | fault_rise;
    wire logic [15:0] next_irq_mask   = wr_irq_mask ? wdata_in : irq_mask;
    wire logic [15:0] next_control    = wr_control ? (wdata_in & 16'h0001) : control;
    wire logic        comm_on         = control[comm_bit];

    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            irq_status <= 16'h0000;
        end else begin
            irq_status <= next_irq_status;
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            irq_mask <= fault_monitor_pkg::irq_mask_reset;
        end else begin
            irq_mask <= next_irq_mask;
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            control <= fault_monitor_pkg::control_reset;
        end else begin
            control <= next_control;
        end
    end

    // fault status has no write strobe, so writes to it fall away
    logic [15:0] rd_mux;
    always_comb begin
        unique case (addr_in)
            fault_monitor_pkg::fault_status_addr: rd_mux = fault_status;
            fault_monitor_pkg::irq_status_addr:   rd_mux = irq_status;
            fault_monitor_pkg::irq_mask_addr:     rd_mux = irq_mask;
            fault_monitor_pkg::control_addr:      rd_mux = control;
            default:                              rd_mux = 16'h0000;
        endcase
    end

    // read data stand one cycle, zero otherwise
    wire logic [15:0] next_rdata = rd_in ? rd_mux : 16'h0000;
    // irq follows the new status and mask together
    wire logic        next_irq   = |(next_irq_status & next_irq_mask);

    fault_monitor_pkg::lamp_s next_lamps;
    assign next_lamps.run        = comm_on;
    // lamps read the synchronised terms the status bits use, so both move on one edge
    assign next_lamps.low_fault  = diag_low;
    assign next_lamps.high_fault = diag_high;

    // every output leaves straight from a flop
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            rdata_out <= 16'h0000;
        end else begin
            rdata_out <= next_rdata;
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            run_lamp_out <= 1'b0;
        end else begin
            run_lamp_out <= next_lamps.run;
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            low_group_fault_lamp_out <= 1'b0;
        end else begin
            low_group_fault_lamp_out <= next_lamps.low_fault;
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            high_group_fault_lamp_out <= 1'b0;
        end else begin
            high_group_fault_lamp_out <= next_lamps.high_fault;
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            irq_out <= 1'b0;
        end else begin
            irq_out <= next_irq;
        end
    end
endmodule
`default_nettype wire

// >>> sim/output_fault_monitor_properties.sv
`timescale 1ns/1ps
`default_nettype none
module output_fault_monitor_properties #(parameter int pulse_half = 4) (
    input wire logic sys_clk_in,
    input wire logic rst_in,
    input wire logic [15:0] out_cmd_in,
    input wire logic [15:0] overload_in,
    input wire logic undervolt_low_in,
    input wire logic [3:0] addr_in,
    input wire logic rd_in,
    input wire logic [15:0] rdata_out,
    input wire logic [15:0] out_drive_out,
    input wire logic low_group_fault_lamp_out,
    input wire logic high_group_fault_lamp_out
);
    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (rst_in);
    // five samples: two sync stages, then the registered outputs
    a_low_lamp_on: assert property ((|overload_in[7:0]) [*5] |->
        low_group_fault_lamp_out) else $error("low lamp dark");
    a_low_lamp_off: assert property ((!overload_in[7:0] && !undervolt_low_in) [*5] |->
        !low_group_fault_lamp_out) else $error("low lamp stuck");
    a_high_lamp_on: assert property ((|overload_in[15:8]) [*5] |->
        high_group_fault_lamp_out) else $error("high lamp dark");
    a_low_status_set: assert property ((|overload_in[7:0]) [*5] ##0 (rd_in && addr_in == 4'h0)
        |=> rdata_out[0]) else $error("status bit 0 clear");
    a_high_status_set: assert property ((|overload_in[15:8]) [*5] ##0 (rd_in && addr_in == 4'h0)
        |=> rdata_out[1]) else $error("status bit 1 clear");
    a_status_self_clear: assert property ((!overload_in) [*5] ##0 (rd_in && addr_in == 4'h0)
        |=> rdata_out[1:0] == 2'b00) else $error("status stuck");
    a_drive_follows: assert property ((!overload_in && $stable(out_cmd_in)) [*6] |->
        out_drive_out == out_cmd_in) else $error("drive differs from command");
    a_chop_runs: assert property ((overload_in[0] && out_cmd_in[0]) [*8] |->
        ##[0:8] !out_drive_out[0]) else $error("faulty output not chopped");
endmodule
bind output_fault_monitor output_fault_monitor_properties #(.pulse_half(pulse_half))
    chk (.*);
`default_nettype wire

// >>> sim/actuator_load.sv
`timescale 1ns/1ps
`default_nettype none
module actuator_load (
    input  wire logic [15:0] cmd_in,
    input  wire logic [15:0] short_in,
    output logic      [15:0] sense_out
);
    // sensed on command, so a chopped output keeps reporting its short
    assign sense_out = cmd_in & short_in;
endmodule
`default_nettype wire

// >>> sim/test_output_fault_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module test_output_fault_monitor;
    logic clk = '0, rst = '1, wr = '0, rd = '0, uvl = '0, uvh = '0, run, lo, hi, irq;
    logic [3:0] adr = '0;
    logic [15:0] cmd = 16'hffff, sh = '0, wd = '0, ov, rdat, drv;
    int fail_count = 0, total_checks = 0, n;
    actuator_load load (.cmd_in(cmd), .short_in(sh), .sense_out(ov));
    output_fault_monitor #(.pulse_half(4)) dut (.sys_clk_in(clk), .rst_in(rst),
        .out_cmd_in(cmd), .overload_in(ov), .undervolt_low_in(uvl), .undervolt_high_in(uvh),
        .addr_in(adr), .wdata_in(wd), .wr_in(wr), .rd_in(rd), .rdata_out(rdat),
        .out_drive_out(drv), .run_lamp_out(run), .low_group_fault_lamp_out(lo),
        .high_group_fault_lamp_out(hi), .irq_out(irq));
    initial forever #5 clk = ~clk;
    task chk(input string s, input logic [15:0] e, g);
        total_checks++;
        if (g !== e) begin fail_count++; $display("[FAIL] %s expected %h seen %h", s, e, g); end
    endtask
    task w(input int c); repeat (c) @(posedge clk); #1; endtask
    task wreg(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk) {adr, wd, wr} <= {a, d, 1'b1};
        @(posedge clk) wr <= 1'b0;
    endtask
    task rreg(input logic [3:0] a, input logic [15:0] e);
        @(posedge clk) {adr, rd} <= {a, 1'b1};
        @(posedge clk) rd <= 1'b0;
        #1 chk("rdata", e, rdat);
    endtask
    task lamps(input logic [15:0] e); chk("lamps", e, {13'h0, run, lo, hi}); endtask
    task conclude;
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        rreg(4'h0, 16'h0000);
        wreg(4'h3, 16'h0001); wreg(4'h2, 16'h0003); w(1);
        lamps(16'h0004);
        sh = 16'h0001; w(6);
        lamps(16'h0006);
        rreg(4'h0, 16'h0001);
        rreg(4'h1, 16'h0001);
        chk("irq", 16'h0001, {15'h0, irq});
        n = 0; repeat (16) begin @(posedge clk); #1 n += !drv[0]; end
        chk("chop", 16'h0008, n[15:0]);
        wreg(4'h0, 16'hffff); rreg(4'h0, 16'h0001);
        sh = 16'h0800; w(6);
        lamps(16'h0005);
        rreg(4'h0, 16'h0002);
        sh = 16'h0000; w(6);
        lamps(16'h0004);
        rreg(4'h0, 16'h0000);
        rreg(4'h1, 16'h0003);
        chk("irq", 16'h0001, {15'h0, irq});
        wreg(4'h1, 16'h0003);
        w(1);
        chk("irq", 16'h0000, {15'h0, irq});
        rreg(4'hf, 16'h0000);
        w(1);
        chk("rdata idle", 16'h0000, rdat);
        uvl = 1'b1; w(6);
        lamps(16'h0006);
        rreg(4'h0, 16'h0000);
        uvl = 1'b0; uvh = 1'b1; w(6);
        lamps(16'h0005);
        rreg(4'h0, 16'h0000);
        conclude();
    end
endmodule
`default_nettype wire
